// ### core/mps_pkg.sv
// constants, types and register map of the memory partition size registers
// assumes an apb master on ref_clk with 32-bit data and word-aligned offsets
// ****************************************************************************
// Functional notes
// RL1 - nonzero bits 15..10 of user data base set user data region base in ram
// RL2 - bits 9..0 of user data base read zero and ignore writes
// RL3 - reset clears user data base, all ram goes to kernel data
// RL4 - software keeps user data base above kernel program base
// RL5 - software keeps user data base at or below data ram size
// RL6 - bits 31..16 of user data base always read zero
// RL7 - program flash size is a read-only static byte count, 16 to 256 KB
// RL8 - boot flash size is a read-only static byte count, 0xc00 for 3 KB
// RL9 - writes to read-only registers or bits change nothing, raise no error
// ****************************************************************************
package mps_pkg;
  localparam logic [11:0] MPS_OFF_USER_DATA_BASE = 12'h000;
  localparam logic [11:0] MPS_OFF_PROGRAM_FLASH_SIZE = 12'h004;
  localparam logic [11:0] MPS_OFF_BOOT_FLASH_SIZE = 12'h008;
  localparam logic [11:0] MPS_OFF_LIMIT_STATUS = 12'h00c;
  localparam int MPS_BASE_LSB = 10;
  localparam int MPS_BASE_MSB = 15;
  localparam logic [5:0] MPS_BASE_RESET = 6'h00;
  localparam logic [31:0] MPS_PROG_FLASH_16K = 32'h0000_4000;
  localparam logic [31:0] MPS_PROG_FLASH_32K = 32'h0000_8000;
  localparam logic [31:0] MPS_PROG_FLASH_64K = 32'h0001_0000;
  localparam logic [31:0] MPS_PROG_FLASH_128K = 32'h0002_0000;
  localparam logic [31:0] MPS_PROG_FLASH_256K = 32'h0004_0000;
  localparam logic [31:0] MPS_BOOT_FLASH_3K = 32'h0000_0c00;
  localparam int MPS_LIM_BELOW_KERNEL = 0;
  localparam int MPS_LIM_ABOVE_RAM = 1;
  localparam int MPS_LIM_USER_ON = 2;

  typedef enum logic [1:0] {
    MPS_APB_IDLE,
    MPS_APB_ACCESS
  } mps_apb_state_t;

  typedef struct packed {
    logic [5:0] base;
  } mps_part_state_t;

  typedef struct packed {
    mps_apb_state_t phase;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] user_base_addr;
    logic user_region_on;
    logic [2:0] limits;
  } mps_top_state_t;
endpackage

// ### core/mps_part_if.sv
// carrier between the apb front and the partition register
// assumes one ref_clk domain
interface mps_part_if;
  logic wr;
  logic [5:0] wdata;
  logic [5:0] base;
  modport front (output wr, output wdata, input base);
  modport part (input wr, input wdata, output base);
endinterface

// ### core/mps_part_reg.sv
// user data base partition register, 1 KB granular
// assumes write strobes from the apb front on ref_clk
module mps_part_reg
  import mps_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // carrier
  mps_part_if.part port_if
);
  mps_part_state_t state;
  mps_part_state_t next_state;

  always_comb begin
    next_state = state;
    if (port_if.wr) begin
      next_state.base = port_if.wdata; // RL1
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state.base <= MPS_BASE_RESET; // RL3
    end else begin
      state <= next_state;
    end
  end

  assign port_if.base = state.base;
endmodule

// ### core/mps_regs.sv
// apb slave for the data ram partition and flash size registers
// assumes an apb master on ref_clk; the kernel base and ram size are inputs
module mps_regs
  import mps_pkg::*;
#(
  parameter logic [31:0] PROGRAM_FLASH_BYTES = MPS_PROG_FLASH_128K,
  parameter logic [31:0] BOOT_FLASH_BYTES = MPS_BOOT_FLASH_3K
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // limits from the companion partition registers
  input wire logic [31:0] kernel_program_base_addr,
  input wire logic [31:0] data_ram_size,
  // partition outputs
  output logic [31:0] user_base_addr,
  output logic user_region_on,
  output logic [2:0] limits
);
  // ****************************************************************************
  // elaboration checks
  // ****************************************************************************
  // only the five listed byte counts are legal program flash sizes
  if (PROGRAM_FLASH_BYTES != MPS_PROG_FLASH_16K && PROGRAM_FLASH_BYTES != MPS_PROG_FLASH_32K &&
      PROGRAM_FLASH_BYTES != MPS_PROG_FLASH_64K && PROGRAM_FLASH_BYTES != MPS_PROG_FLASH_128K &&
      PROGRAM_FLASH_BYTES != MPS_PROG_FLASH_256K) begin
    $error("program flash size not supported");
  end

  // ****************************************************************************
  // address decode
  // ****************************************************************************
  function automatic logic is_reg(input logic [11:0] addr, input logic [11:0] off);
    is_reg = (addr == off);
  endfunction

  mps_part_if part_if ();
  mps_top_state_t state;
  mps_top_state_t next_state;
  logic [31:0] base_word;
  logic unmapped;

  mps_part_reg u_part (
    .ref_clk(ref_clk),
    .reset(reset),
    .port_if(part_if)
  );

  // bits 31..16 and 9..0 are tied low
  assign base_word = {16'h0000, part_if.base, 10'h000}; // RL2 RL6
  assign unmapped = !(is_reg(paddr, MPS_OFF_USER_DATA_BASE) ||
                      is_reg(paddr, MPS_OFF_PROGRAM_FLASH_SIZE) ||
                      is_reg(paddr, MPS_OFF_BOOT_FLASH_SIZE) ||
                      is_reg(paddr, MPS_OFF_LIMIT_STATUS));

  // ****************************************************************************
  // apb sequencing
  // ****************************************************************************
  always_comb begin
    next_state = state;
    next_state.pready = 1'b0;
    next_state.pslverr = 1'b0;
    part_if.wr = 1'b0;
    // only byte lane 1 (pstrb[1]) carries writable bits
    part_if.wdata = pwdata[MPS_BASE_MSB:MPS_BASE_LSB];
    case (state.phase)
      MPS_APB_IDLE: begin
        if (psel && !penable) begin
          next_state.phase = MPS_APB_ACCESS;
        end
      end
      MPS_APB_ACCESS: begin
        if (!state.pready) begin
          // answer one cycle into the access phase
          next_state.pready = 1'b1;
          next_state.pslverr = unmapped;
          if (pwrite && is_reg(paddr, MPS_OFF_USER_DATA_BASE) && pstrb[1]) begin
            part_if.wr = 1'b1; // RL1
          end
          // writes to other mapped registers are dropped silently
          next_state.prdata = 32'h0000_0000; // RL9
          if (!pwrite) begin
            if (is_reg(paddr, MPS_OFF_USER_DATA_BASE)) begin
              next_state.prdata = base_word; // RL6
            end else if (is_reg(paddr, MPS_OFF_PROGRAM_FLASH_SIZE)) begin
              next_state.prdata = PROGRAM_FLASH_BYTES; // RL7
            end else if (is_reg(paddr, MPS_OFF_BOOT_FLASH_SIZE)) begin
              next_state.prdata = BOOT_FLASH_BYTES; // RL8
            end else if (is_reg(paddr, MPS_OFF_LIMIT_STATUS)) begin
              next_state.prdata = {29'h0000_0000, state.limits};
            end
          end
        end else begin
          next_state.phase = MPS_APB_IDLE;
        end
      end
      default: begin
        next_state.phase = MPS_APB_IDLE;
      end
    endcase
    // zero base keeps all ram in kernel data
    next_state.user_region_on = (part_if.base != 6'h00); // RL1
    next_state.user_base_addr = base_word; // RL1
    // software limits are flagged only, never enforced
    next_state.limits[MPS_LIM_BELOW_KERNEL] = next_state.user_region_on &&
      (base_word <= kernel_program_base_addr); // RL4
    next_state.limits[MPS_LIM_ABOVE_RAM] = base_word > data_ram_size; // RL5
    next_state.limits[MPS_LIM_USER_ON] = next_state.user_region_on;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state.phase <= MPS_APB_IDLE;
      state.prdata <= 32'h0000_0000;
      state.pready <= 1'b0;
      state.pslverr <= 1'b0;
      state.user_base_addr <= 32'h0000_0000; // RL3
      state.user_region_on <= 1'b0;
      state.limits <= 3'h0;
    end else begin
      state <= next_state;
    end
  end

  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign user_base_addr = state.user_base_addr;
  assign user_region_on = state.user_region_on;
  assign limits = state.limits;
endmodule

// ### tb/mps_regs_monitor.sv
// checker for the partition and flash size registers
// assumes it is bound to mps_regs, one ref_clk domain
module mps_regs_monitor
  import mps_pkg::*;
#(
  parameter logic [31:0] PROGRAM_FLASH_BYTES = 32'h0,
  parameter logic [31:0] BOOT_FLASH_BYTES = 32'h0
) (
  // clock, reset and apb
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // limits and partition
  input wire logic [31:0] kernel_program_base_addr,
  input wire logic [31:0] data_ram_size,
  input wire logic [31:0] user_base_addr,
  input wire logic user_region_on,
  input wire logic [2:0] limits
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // checks
  // ******
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire rd_done = pready && !pwrite;
  chk_base_low_zero: assert property (
    rd_done && paddr == 12'h000 |-> prdata[9:0] == 10'h000) else $error("base low bits set");
  chk_base_high_zero: assert property (
    rd_done && paddr == 12'h000 |-> prdata[31:16] == 16'h0000) else $error("base high bits set");
  chk_prog_size_value: assert property (
    rd_done && paddr == 12'h004 |-> prdata == PROGRAM_FLASH_BYTES) else $error("bad flash size");
  chk_boot_size_value: assert property (
    rd_done && paddr == 12'h008 |-> prdata == BOOT_FLASH_BYTES) else $error("bad boot size");
  chk_base_follows: assert property (
    pready && pwrite && paddr == 12'h000 && pstrb[1] |->
    ##2 user_base_addr[15:10] == $past(pwdata[15:10], 2)) else $error("base not taken");
  chk_ro_write: assert property (
    pready && pwrite && paddr inside {12'h004, 12'h008} |-> !pslverr ##1 $stable(user_base_addr))
    else $error("read-only write had effect");
  chk_region_flag: assert property (
    user_region_on == (user_base_addr[15:10] != 6'h00)) else $error("region flag wrong");
  chk_reset_clear: assert property (
    $fell(reset) |-> user_base_addr == 32'h0 && !user_region_on) else $error("not cleared");
  chk_err_mapped: assert property (
    pslverr |-> pready && !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c}))
    else $error("error on mapped register");
endmodule

bind mps_regs mps_regs_monitor #(
  .PROGRAM_FLASH_BYTES(PROGRAM_FLASH_BYTES),
  .BOOT_FLASH_BYTES(BOOT_FLASH_BYTES)
) i_mon (.*);

// ### tb/testbench.sv
// self-checking bench for the partition and flash size registers
// assumes the apb slave answers with pready, one transfer at a time
module testbench
  import mps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] kernel_program_base_addr = 32'h0000_0400;
  logic [31:0] data_ram_size = 32'h0000_8000;
  logic [31:0] prdata;
  logic [31:0] user_base_addr;
  logic pready;
  logic pslverr;
  logic user_region_on;
  logic [2:0] limits;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  always #10 ref_clk = ~ref_clk;
  mps_regs #(.PROGRAM_FLASH_BYTES(MPS_PROG_FLASH_64K)) i_dut (.*);
  // ***********
  // bus helpers
  // ***********
  task automatic report_and_stop();
    $display("errors %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
      bad_count++;
    end
  endtask
  // one apb transfer; read data checked only on reads
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] x, input logic [3:0] s, input logic xe);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    if (!w) chk(prdata, x);
    chk({31'h0, pslverr}, {31'h0, xe});
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    xfer(0, 12'h000, 32'h0, 32'h0, 4'hf, 0);
    xfer(1, 12'h000, 32'hffff_7fff, 32'h0, 4'hf, 0);
    xfer(0, 12'h000, 32'h0, 32'h0000_7c00, 4'hf, 0);
    chk(user_base_addr, 32'h0000_7c00);
    chk({28'h0, user_region_on, limits}, 32'hc);
    xfer(0, 12'h00c, 32'h0, 32'h0000_0004, 4'hf, 0);
    kernel_program_base_addr <= 32'h0000_8000;
    data_ram_size <= 32'h0000_4000;
    @(posedge ref_clk);
    @(posedge ref_clk);
    xfer(0, 12'h00c, 32'h0, 32'h0000_0007, 4'hf, 0);
    chk({29'h0, limits}, 32'h7);
    xfer(1, 12'h000, 32'h0, 32'h0, 4'h1, 0);
    xfer(0, 12'h000, 32'h0, 32'h0000_7c00, 4'hf, 0);
    xfer(1, 12'h004, 32'hffff_ffff, 32'h0, 4'hf, 0);
    xfer(0, 12'h004, 32'h0, MPS_PROG_FLASH_64K, 4'hf, 0);
    xfer(1, 12'h008, 32'hffff_ffff, 32'h0, 4'hf, 0);
    xfer(0, 12'h008, 32'h0, MPS_BOOT_FLASH_3K, 4'hf, 0);
    xfer(0, 12'h010, 32'h0, 32'h0, 4'hf, 1);
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    xfer(0, 12'h000, 32'h0, 32'h0, 4'hf, 0);
    chk({31'h0, user_region_on}, 32'h0);
    report_and_stop();
  end
endmodule
